/* rtl/ctt_top.sv */
// Commutation tuning register with method selection and demagnetization check.
`timescale 1ns/1ps
module ctt_top
  import ctt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        nv_load,
  input  wire logic [31:0] nv_word,
  output logic             parity_err,
  input  wire logic        speed_valid,
  input  wire logic [7:0]  samples_per_30deg,
  input  wire logic [6:0]  duty_pct,
  output logic             zc_mode,
  input  wire logic        demag_start,
  input  wire logic        phase_valid,
  input  wire logic [15:0] phase_mv,
  input  wire logic [15:0] motor_supply_mv,
  output logic             demag_done,
  output logic [11:0]      falling_phase_integ_thr,
  output logic [11:0]      rising_phase_integ_thr
);
  import ctt_pkg::*;

  // --------------------------------------------------------------------------
  // Register and field decode
  // --------------------------------------------------------------------------
  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic [31:0] next_rdata;
  logic        next_rvalid;
  logic        next_parity_err;
  logic [1:0]  demag_sample_count;
  logic [1:0]  demag_upper_bound;
  logic [1:0]  demag_lower_bound;
  logic [1:0]  samples_switch_down_thr;
  logic [1:0]  samples_switch_up_thr;
  logic [1:0]  duty_switch_down_thr;
  logic [1:0]  duty_switch_up_thr;
  logic [11:0] fall_val;
  logic [11:0] rise_val;

  assign demag_sample_count      = cfg[DEMAG_CNT_POS   +: 2];
  assign demag_upper_bound       = cfg[DEMAG_UPPER_POS +: 2];
  assign demag_lower_bound       = cfg[DEMAG_LOWER_POS +: 2];
  assign samples_switch_down_thr = cfg[SMP_DOWN_POS    +: 2];
  assign samples_switch_up_thr   = cfg[SMP_UP_POS      +: 2];
  assign duty_switch_down_thr    = cfg[DUTY_DOWN_POS   +: 2];
  assign duty_switch_up_thr      = cfg[DUTY_UP_POS     +: 2];

  ctt_thr_decode u_fall (
    .code  (cfg[FALL_THR_POS +: 6]),
    .value (fall_val)
  );

  ctt_thr_decode u_rise (
    .code  (cfg[RISE_THR_POS +: 6]),
    .value (rise_val)
  );

  // --------------------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------------------
  always_comb begin
    next_cfg        = cfg;
    next_rdata      = reg_rdata;
    next_rvalid     = 1'b0;
    next_parity_err = parity_err;
    if (reg_wr && reg_addr == REG_ADDR) begin
      next_cfg = reg_wdata;
    end
    if (nv_load) begin
      next_cfg        = nv_word;
      next_parity_err = ^nv_word;
    end
    // Reads of any other address return zero so stray polls are harmless.
    if (reg_rd) begin
      next_rvalid = 1'b1;
      next_rdata  = (reg_addr == REG_ADDR) ? cfg : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg        <= REG_RESET;
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
      parity_err <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
      parity_err <= next_parity_err;
    end
  end

  // --------------------------------------------------------------------------
  // Commutation method selection
  // --------------------------------------------------------------------------
  ctt_method_t method;
  ctt_method_t next_method;
  logic        next_zc_mode;
  logic        smp_low;
  logic        smp_high;
  logic        duty_low;
  logic        duty_high;

  always_comb begin
    smp_low     = samples_per_30deg < SMP_DOWN_TBL[samples_switch_down_thr];
    smp_high    = samples_per_30deg > SMP_UP_TBL[samples_switch_up_thr];
    duty_low    = duty_pct < DUTY_TBL[duty_switch_down_thr];
    duty_high   = duty_pct > DUTY_TBL[duty_switch_up_thr];
    next_method = method;
    if (speed_valid) begin
      unique case (method)
        CTT_INTEG: begin
          if (smp_low || duty_low) begin
            next_method = CTT_ZC;
          end
        end
        CTT_ZC: begin
          // Both conditions are needed so a marginal input cannot chatter.
          if (smp_high && duty_high) begin
            next_method = CTT_INTEG;
          end
        end
      endcase
    end
    next_zc_mode = (next_method == CTT_ZC);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      method  <= CTT_ZC;
      zc_mode <= 1'b1;
    end else begin
      method  <= next_method;
      zc_mode <= next_zc_mode;
    end
  end

  // --------------------------------------------------------------------------
  // Dynamic demagnetization check
  // --------------------------------------------------------------------------
  logic        demag_busy;
  logic        next_demag_busy;
  logic [2:0]  demag_hits;
  logic [2:0]  next_demag_hits;
  logic        next_demag_done;
  logic        in_window;
  logic [15:0] upper_mv;

  always_comb begin
    upper_mv  = motor_supply_mv - {8'h00, DEMAG_UPPER_TBL[demag_upper_bound]};
    in_window = (phase_mv > {8'h00, DEMAG_LOWER_TBL[demag_lower_bound]}) &&
                (phase_mv < upper_mv);
    next_demag_busy = demag_busy;
    next_demag_hits = demag_hits;
    next_demag_done = 1'b0;
    // A start while a check runs restarts the count from zero.
    if (demag_start) begin
      next_demag_busy = 1'b1;
      next_demag_hits = 3'h0;
    end else if (demag_busy && phase_valid) begin
      if (!in_window) begin
        next_demag_hits = 3'h0;
      end else if (demag_hits + 3'h1 >= DEMAG_CNT_TBL[demag_sample_count]) begin
        next_demag_done = 1'b1;
        next_demag_busy = 1'b0;
        next_demag_hits = 3'h0;
      end else begin
        next_demag_hits = demag_hits + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      demag_busy <= 1'b0;
      demag_hits <= 3'h0;
      demag_done <= 1'b0;
    end else begin
      demag_busy <= next_demag_busy;
      demag_hits <= next_demag_hits;
      demag_done <= next_demag_done;
    end
  end

  // --------------------------------------------------------------------------
  // Decoded integration thresholds
  // --------------------------------------------------------------------------
  // Registered so the commutation engine sees a value one cycle behind the
  // register, never a decode glitch from a word that is still changing.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      falling_phase_integ_thr <= 12'h000;
      rising_phase_integ_thr  <= 12'h000;
    end else begin
      falling_phase_integ_thr <= fall_val;
      rising_phase_integ_thr  <= rise_val;
    end
  end

endmodule

/* inc/ctt_pkg.sv */
// Constants, field layout and code tables of the commutation tuning register.
package ctt_pkg;

  // --------------------------------------------------------------------------
  // Register placement
  // --------------------------------------------------------------------------
  localparam logic [7:0]  REG_ADDR  = 8'h8A;
  localparam logic [31:0] REG_RESET = 32'h1400_0000;

  // --------------------------------------------------------------------------
  // Field positions (low bit of each field)
  // --------------------------------------------------------------------------
  localparam int PARITY_POS       = 31;
  localparam int DEMAG_CNT_POS    = 29;
  localparam int DEMAG_UPPER_POS  = 27;
  localparam int DEMAG_LOWER_POS  = 25;
  localparam int SMP_DOWN_POS     = 23;
  localparam int SMP_UP_POS       = 21;
  localparam int DUTY_DOWN_POS    = 19;
  localparam int DUTY_UP_POS      = 17;
  localparam int FALL_THR_POS     = 11;
  localparam int RISE_THR_POS     = 5;

  // --------------------------------------------------------------------------
  // Code tables, voltages in millivolts, duty in percent
  // --------------------------------------------------------------------------
  localparam logic [2:0]  DEMAG_CNT_TBL   [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
  localparam logic [7:0]  DEMAG_UPPER_TBL [4] = '{8'h5A, 8'h78, 8'h96, 8'hB4};
  localparam logic [7:0]  DEMAG_LOWER_TBL [4] = '{8'h1E, 8'h3C, 8'h5A, 8'h78};
  localparam logic [7:0]  SMP_DOWN_TBL    [4] = '{8'h03, 8'h04, 8'h06, 8'h08};
  localparam logic [7:0]  SMP_UP_TBL      [4] = '{8'h04, 8'h06, 8'h08, 8'h0A};
  localparam logic [6:0]  DUTY_TBL        [4] = '{7'h0C, 7'h0F, 7'h12, 7'h14};

  // --------------------------------------------------------------------------
  // Integration threshold scale
  // --------------------------------------------------------------------------
  localparam logic [5:0]  THR_KNEE1 = 6'h20;
  localparam logic [5:0]  THR_KNEE2 = 6'h30;
  localparam logic [5:0]  THR_KNEE3 = 6'h38;
  localparam logic [11:0] THR_STEP1 = 12'h019;
  localparam logic [11:0] THR_STEP2 = 12'h032;
  localparam logic [11:0] THR_STEP3 = 12'h064;
  localparam logic [11:0] THR_STEP4 = 12'h0C8;
  localparam logic [11:0] THR_BASE2 = 12'h320;
  localparam logic [11:0] THR_BASE3 = 12'h640;
  localparam logic [11:0] THR_BASE4 = 12'h960;

  typedef enum logic [0:0] {
    CTT_INTEG = 1'b0,
    CTT_ZC    = 1'b1
  } ctt_method_t;

endpackage

/* rtl/ctt_thr_decode.sv */
// Six-bit integration threshold code to threshold value.
`timescale 1ns/1ps
module ctt_thr_decode
  import ctt_pkg::*;
(
  input  wire logic [5:0]  code,
  output logic      [11:0] value
);

  logic [11:0] code_w;

  assign code_w = {6'h00, code};

  always_comb begin
    if (code <= THR_KNEE1) begin
      value = 12'(code_w * THR_STEP1);
    end else if (code <= THR_KNEE2) begin
      value = 12'(THR_BASE2 + (code_w - {6'h00, THR_KNEE1}) * THR_STEP2);
    end else if (code <= THR_KNEE3) begin
      value = 12'(THR_BASE3 + (code_w - {6'h00, THR_KNEE2}) * THR_STEP3);
    end else begin
      value = 12'(THR_BASE4 + (code_w - {6'h00, THR_KNEE3}) * THR_STEP4);
    end
  end

endmodule

/* verif/ctt_top_asserts.sv */
// Port checker for the commutation tuning block.
`timescale 1ns/1ps
module ctt_top_asserts
  import ctt_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        nv_load,
  input wire logic [31:0] nv_word,
  input wire logic        parity_err,
  input wire logic        speed_valid,
  input wire logic        zc_mode,
  input wire logic        demag_start,
  input wire logic        demag_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  rd_unmapped_a:
    assert property (reg_rd && reg_addr != REG_ADDR |=> reg_rdata == '0) else $error("stray read");
  par_load_a:
    assert property (nv_load |=> parity_err == ^$past(nv_word)) else $error("parity flag wrong");
  par_hold_a:
    assert property (!nv_load |=> $stable(parity_err)) else $error("flag moved");
  zc_hold_a:
    assert property (!speed_valid |=> $stable(zc_mode)) else $error("mode moved");
  zc_reset_a: assert property ($fell(sys_rst) |-> zc_mode) else $error("reset mode");
  done_pulse_a: assert property (demag_done |=> !demag_done) else $error("done too long");
  done_wait_a:
    assert property (demag_start |=> !demag_done [*2]) else $error("done too early");
  cover property ($fell(zc_mode));
  cover property (nv_load ##1 parity_err);
  cover property (demag_done);
endmodule

/* verif/ctt_motor_model.sv */
// Floating-phase source standing in for the motor windings.
`timescale 1ns/1ps
module ctt_motor_model (
  input  wire logic        ref_clk,
  input  wire logic        en,
  input  wire logic        edg,
  input  wire logic [15:0] edge_mv,
  output logic             phase_valid,
  output logic [15:0]      phase_mv,
  output logic [15:0]      motor_supply_mv
);
  logic [15:0] last_mv = 16'h0000;
  // Idle samples toggle, so a check that reads them anyway cannot pass by luck.
  assign phase_valid = en;
  assign motor_supply_mv = 16'h5DC0;
  assign phase_mv = !en ? ~last_mv : edg ? edge_mv : 16'h2EE0;
  always @(posedge ref_clk) last_mv <= phase_mv;
endmodule

/* verif/commutation_demag_tuning_tb.sv */
// Self-checking bench for the commutation tuning block.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module commutation_demag_tuning_tb;
  import ctt_pkg::*;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, nv_load = 0, speed_valid = 0, en = 0;
  logic demag_start = 0, edg = 0, hit, reg_rvalid, parity_err, zc_mode, demag_done, phase_valid;
  logic [6:0] duty_pct = 0;
  logic [7:0] reg_addr = 0, samples_per_30deg = 0;
  logic [11:0] falling_phase_integ_thr, rising_phase_integ_thr;
  logic [15:0] edge_mv = 0, phase_mv, motor_supply_mv;
  logic [31:0] reg_wdata = 0, nv_word = 0, reg_rdata, w, e, q[$];
  int fail_count = 0, cmp_count = 0, cyc = 0, seed = 32'hB4DBA8D2;
  byte sd[4] = '{3, 4, 6, 8}, su[4] = '{4, 6, 8, 10}, dt[4] = '{12, 15, 18, 20};
  byte tc[10] = '{0, 1, 31, 32, 33, 48, 49, 56, 57, 63};
  ctt_top dut_u (.*);
  ctt_motor_model mot_u (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 3000) begin
    fail_count++;
    finish_test;
  end
  always @(negedge ref_clk) if (reg_rvalid !== 1'b0) begin
    e = q.size() ? q.pop_front() : 'X;
    `CHK(reg_rdata, e) // read data
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk) reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    q.push_back(d);
    @(negedge ref_clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk) reg_rd = 0;
  endtask
  task automatic m(input int s, input int d, input logic z);
    @(negedge ref_clk) {samples_per_30deg, duty_pct, speed_valid} = {s[7:0], d[6:0], 1'b1};
    @(negedge ref_clk) speed_valid = 0;
    `CHK(zc_mode, z) // method
  endtask
  function automatic logic [11:0] thr(input int c);
    if (c <= 32) return 12'(c * 25);
    if (c <= 48) return 12'(800 + (c - 32) * 50);
    if (c <= 56) return 12'(1600 + (c - 48) * 100);
    return 12'(2400 + (c - 56) * 200);
  endfunction
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 0;
    `CHK(zc_mode, 1'b1) // reset method
    rd(8'h8A, 32'h1400_0000); // reset word
    rd(8'h8B, 32'h0); // stray read
    for (int c = 0; c < 4; c++) begin
      wr(8'h8A, (c << 23) | (c << 21) | (c << 19) | (c << 17)); // codes
      m(su[c] + 1, dt[c] + 1, 0); // both above
      m(sd[c], dt[c] - 1, 1); // duty below
      m(su[c] + 1, dt[c], 1); // duty equal
      m(su[c], dt[c] + 5, 1); // samples equal
      m(su[c] + 1, dt[c] + 1, 0); // both above
      m(sd[c] - 1, dt[c] + 5, 1); // samples below
    end
    for (int k = 0; k < 10; k++) begin
      w = $random(seed);
      {w[16:11], w[10:5]} = {tc[k][5:0], tc[9 - k][5:0]};
      wr(8'h8A, w); // codes
      wr(8'h8C, ~w); // stray write
      rd(8'h8A, w); // read back
      `CHK(falling_phase_integ_thr, thr(tc[k])) // falling scale
      `CHK(rising_phase_integ_thr, thr(tc[9 - k])) // rising scale
    end
    w = $random(seed);
    // The second load flips one bit so that both values of the flag are seen.
    for (int p = 0; p < 2; p++) begin
      w[0] = w[0] ^ p[0];
      @(negedge ref_clk) begin
        {reg_addr, nv_word, nv_load} = {8'h8A, w, 1'b1};
        {reg_wdata, reg_wr} = {~w, 1'b1};
      end
      @(negedge ref_clk) {nv_load, reg_wr} = 2'b00;
      `CHK(parity_err, ^w) // parity flag
      rd(8'h8A, w); // load wins
    end
    for (int n = 0; n < 4; n++) begin
      wr(8'h8A, (n << 29) | (n << 27) | (n << 25)); // codes
      @(negedge ref_clk) demag_start = 1;
      @(negedge ref_clk) demag_start = 0;
      // A sample on a bound lies outside the window.
      edge_mv = 16'(n[0] ? 24000 - 90 - 30 * n : 30 + 30 * n);
      for (int k = 0; k < 2 * n + 4; k++) begin
        `CHK(demag_done, 1'b0) // no early end
        {en, edg} = {1'b1, k == n + 1};
        @(negedge ref_clk);
      end
      hit = demag_done;
      en = 0;
      repeat (2) @(negedge ref_clk) hit |= demag_done;
      `CHK(hit, 1'b1) // ends on count
    end
    repeat (3) @(negedge ref_clk);
    `CHK(q.size(), 0) // all answered
    finish_test;
  end
endmodule
bind ctt_top ctt_top_asserts chk_u (.*);
